// *** design/sbfl_pkg.sv ***
// Package with the frame layout, command encodings and timing constants of the southbound link.
package sbfl_pkg;
    // ------------------------------------------------------------------
    // Link geometry and timing
    // ------------------------------------------------------------------
    localparam int LANES = 10;
    localparam int XFERS = 12;
    localparam int FRAME_BITS = LANES * XFERS;
    localparam logic [3:0] LAST_XFER = 4'hB;
    localparam int REF_PERIOD_NS = 4;
    localparam int LANE_RATE_MULT = 12;
    localparam int SYNC_MAX_FRAMES = 42;
    localparam int MAX_CHAIN = 8;
    localparam int FIFO_DEPTH = 8;

    // ------------------------------------------------------------------
    // Field positions inside the 120-bit frame (bit = transfer * 10 + lane)
    // ------------------------------------------------------------------
    localparam int CMD_BITS = 24;
    localparam int CMDA_LSB = 0;
    localparam int FT_LSB = 24;
    localparam int FT_BITS = 6;
    localparam int CRCA_LSB = 30;
    localparam int CRCA_BITS = 14;
    localparam int PAY_LSB = 44;
    localparam int PAY_BITS = 72;
    localparam int CRCP_LSB = 116;
    localparam int CRCP_BITS = 4;
    localparam int HEAD_BITS = 30;
    localparam int CRC_BITS = 18;
    localparam logic [17:0] CRC_POLY = 18'h23C47;

    // ------------------------------------------------------------------
    // Frame type field and command encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] FT_CMD = 2'h0;
    localparam logic [1:0] FT_DATA = 2'h1;
    localparam logic [1:0] FT_CMD_PART = 2'h2;
    localparam logic [1:0] FT_RSVD = 2'h3;
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_SYNC = 4'h1;

    typedef struct packed {
        logic [2:0] slot;
        logic [3:0] opcode;
        logic [16:0] body;
    } sbfl_cmd_s;

    typedef struct packed {
        logic rsvd;
        logic [2:0] slot;
        logic [1:0] ftype;
    } sbfl_ft_s;

    typedef struct packed {
        logic has_data;
        sbfl_cmd_s cmd;
        logic [71:0] wdata;
    } sbfl_entry_s;
endpackage : sbfl_pkg

// *** design/sbfl_link.sv ***
// Southbound frame receiver, redriver and command queue of the module buffer.

// ----------------------------------------------------------------------
// Command FIFO
// ----------------------------------------------------------------------
module sbfl_fifo #(
    parameter int WIDTH = 97,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic do_wr;
    logic do_rd;

    assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (do_wr) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_wr) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (do_rd) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
            end
            if (do_wr && !do_rd) begin
                cnt_q <= cnt_q + (AW + 1)'(1);
            end else if (do_rd && !do_wr) begin
                cnt_q <= cnt_q - (AW + 1)'(1);
            end
        end
    end
endmodule : sbfl_fifo

// ----------------------------------------------------------------------
// Frame receiver
// ----------------------------------------------------------------------
// Contract
// - Ten southbound lanes carry command and write-data frames toward the modules.
// - A frame is twelve transfers of ten bits, one bit per lane.
// - Three frame formats, command, command-with-data and command with partial data, told apart by frame type.
// - Command frame holds three command slots plus CRC over them.
// - Command frames mixing commands with partial write data are also accepted.
// - Each command of a frame may address a different module on the chain.
// - Command-with-data frame holds one command, 72 write bits, CRC over all.
// - A data frame names one slot; only that slot's buffer takes its command.
// - On sync the buffer reports status and restarts its sync-loss frame count.
// - Received lanes are redriven to the next module; up to eight modules.
// - Reference clock is half DRAM clock; lane rate twelve times reference.
// - On a lane fault traffic is remapped onto the redundant lane.
// - The channel address comes from the management interface.
// - Every command slot holds 24 coded bits.
// - Fourteen leftover CRC bits of the previous frame XOR into head CRC.
// - Idle slots carry NOPs; deselect drives the DRAM while nothing is pending.
module sbfl_link (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [9:0] sb_lane_in,
    input wire logic sb_frame_mark,
    output logic [9:0] sb_lane_out,
    input wire logic remap_en,
    input wire logic [3:0] fault_lane,
    input wire logic smb_addr_valid,
    input wire logic [2:0] smb_addr,
    output logic dram_cmd_valid,
    input wire logic dram_cmd_ready,
    output sbfl_pkg::sbfl_entry_s dram_entry,
    output logic dram_deselect,
    output logic status_report,
    output logic frame_err,
    output logic queue_overrun,
    output logic sync_lost
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [17:0] sbfl_crc(input logic [71:0] d, input int n);
        logic [17:0] c;
        logic fb;
        c = '1;
        for (int i = 0; i < 72; i++) begin
            if (i < n) begin
                fb = c[17] ^ d[i];
                c = {c[16:0], 1'b0};
                if (fb) begin
                    c = c ^ sbfl_pkg::CRC_POLY;
                end
            end
        end
        return c;
    endfunction : sbfl_crc

    // The spare top lane takes over when a lane below it has failed.
    function automatic logic [9:0] sbfl_remap(input logic [9:0] p, input logic en,
                                              input logic [3:0] f);
        logic [9:0] l;
        l = p;
        for (int i = 0; i < 9; i++) begin
            if (en && (4'(i) >= f)) begin
                l[i] = p[i + 1];
            end
        end
        if (en) begin
            l[9] = 1'b0;
        end
        return l;
    endfunction : sbfl_remap

    function automatic logic sbfl_takes(input sbfl_pkg::sbfl_cmd_s c, input logic [2:0] a);
        return (c.slot == a) && (c.opcode != sbfl_pkg::OP_NOP)
            && (c.opcode != sbfl_pkg::OP_SYNC);
    endfunction : sbfl_takes

    // ------------------------------------------------------------------
    // Lane capture and redrive
    // ------------------------------------------------------------------
    logic [9:0] lanes_l;
    logic [3:0] xfer_q;
    logic [3:0] xfer_now;
    logic [119:0] frame_q;
    logic [119:0] frame_w;
    logic frame_end;

    // One transfer arrives per reference clock; the serial lane rate is outside this block.
    assign lanes_l = sbfl_remap(sb_lane_in, remap_en, fault_lane);
    assign xfer_now = sb_frame_mark ? 4'h0 : xfer_q;
    assign frame_end = (xfer_now == sbfl_pkg::LAST_XFER);

    always_comb begin
        frame_w = frame_q;
        frame_w[xfer_now * 10 +: 10] = lanes_l;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sb_lane_out <= '0;
        end else begin
            sb_lane_out <= sb_lane_in;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            xfer_q <= '0;
            frame_q <= '0;
        end else begin
            frame_q <= frame_w;
            xfer_q <= frame_end ? 4'h0 : xfer_now + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Frame decode and CRC check
    // ------------------------------------------------------------------
    sbfl_pkg::sbfl_cmd_s cmd_a;
    sbfl_pkg::sbfl_cmd_s cmd_b;
    sbfl_pkg::sbfl_cmd_s cmd_c;
    sbfl_pkg::sbfl_ft_s ft;
    logic [71:0] payload;
    logic [17:0] head_crc;
    logic [17:0] pay_crc;
    logic [13:0] left_q;
    logic frame_ok;
    logic sync_hit;
    logic [2:0] addr_q;
    logic addr_valid_q;

    assign cmd_a = frame_w[sbfl_pkg::CMDA_LSB +: sbfl_pkg::CMD_BITS];
    assign ft = frame_w[sbfl_pkg::FT_LSB +: sbfl_pkg::FT_BITS];
    assign payload = frame_w[sbfl_pkg::PAY_LSB +: sbfl_pkg::PAY_BITS];
    assign cmd_b = payload[23:0];
    assign cmd_c = payload[47:24];
    assign head_crc = sbfl_crc({42'h0, frame_w[29:0]}, sbfl_pkg::HEAD_BITS);
    assign pay_crc = sbfl_crc(payload, sbfl_pkg::PAY_BITS);
    assign frame_ok = (frame_w[sbfl_pkg::CRCA_LSB +: sbfl_pkg::CRCA_BITS]
                       == (head_crc[13:0] ^ left_q))
        && (frame_w[sbfl_pkg::CRCP_LSB +: sbfl_pkg::CRCP_BITS] == pay_crc[3:0])
        && (ft.ftype != sbfl_pkg::FT_RSVD);
    assign sync_hit = (cmd_a.opcode == sbfl_pkg::OP_SYNC)
        || ((ft.ftype != sbfl_pkg::FT_DATA) && (cmd_b.opcode == sbfl_pkg::OP_SYNC))
        || ((ft.ftype == sbfl_pkg::FT_CMD) && (cmd_c.opcode == sbfl_pkg::OP_SYNC));

    // The leftover follows every frame, good or bad, so both ends stay in step.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            left_q <= '0;
        end else if (frame_end) begin
            left_q <= pay_crc[17:4];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= '0;
            addr_valid_q <= 1'b0;
        end else if (smb_addr_valid) begin
            addr_q <= smb_addr;
            addr_valid_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Sync supervision
    // ------------------------------------------------------------------
    logic [5:0] since_sync_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            since_sync_q <= '0;
            status_report <= 1'b0;
            frame_err <= 1'b0;
            sync_lost <= 1'b0;
        end else begin
            status_report <= frame_end && frame_ok && sync_hit;
            frame_err <= frame_end && !frame_ok;
            if (frame_end && frame_ok && sync_hit) begin
                since_sync_q <= '0;
                sync_lost <= 1'b0;
            end else if (frame_end && (since_sync_q != 6'(sbfl_pkg::SYNC_MAX_FRAMES))) begin
                since_sync_q <= since_sync_q + 6'h01;
            end else if (since_sync_q == 6'(sbfl_pkg::SYNC_MAX_FRAMES)) begin
                sync_lost <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pending commands and queue fill
    // ------------------------------------------------------------------
    // Up to three commands per frame drain into the FIFO one per cycle; a frame
    // lasts twelve cycles, so only a full FIFO can make the next frame overrun.
    sbfl_pkg::sbfl_entry_s pend_q [3];
    logic [2:0] pend_v_q;
    logic [1:0] sel;
    logic push_valid;
    logic push_ready;
    logic [2:0] take;
    logic data_hit;

    assign data_hit = (ft.ftype == sbfl_pkg::FT_DATA) && (ft.slot == addr_q);
    assign take[0] = frame_ok && addr_valid_q && sbfl_takes(cmd_a, addr_q)
        && ((ft.ftype != sbfl_pkg::FT_DATA) || data_hit);
    assign take[1] = frame_ok && addr_valid_q && (ft.ftype != sbfl_pkg::FT_DATA)
        && sbfl_takes(cmd_b, addr_q);
    assign take[2] = frame_ok && addr_valid_q && (ft.ftype == sbfl_pkg::FT_CMD)
        && sbfl_takes(cmd_c, addr_q);
    assign sel = pend_v_q[0] ? 2'd0 : (pend_v_q[1] ? 2'd1 : 2'd2);
    assign push_valid = |pend_v_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_v_q <= '0;
            queue_overrun <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                pend_q[i] <= '0;
            end
        end else begin
            queue_overrun <= frame_end && push_valid && (take != '0);
            if (frame_end && (take != '0)) begin
                pend_v_q <= take;
                pend_q[0] <= '{has_data: ft.ftype == sbfl_pkg::FT_DATA, cmd: cmd_a,
                               wdata: payload};
                pend_q[1] <= '{has_data: ft.ftype == sbfl_pkg::FT_CMD_PART, cmd: cmd_b,
                               wdata: {48'h0, payload[47:24]}};
                pend_q[2] <= '{has_data: 1'b0, cmd: cmd_c, wdata: 72'h0};
            end else if (push_valid && push_ready) begin
                pend_v_q[sel] <= 1'b0;
            end
        end
    end

    sbfl_fifo #(
        .WIDTH($bits(sbfl_pkg::sbfl_entry_s)),
        .DEPTH(sbfl_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(pend_q[sel]),
        .out_valid(dram_cmd_valid),
        .out_ready(dram_cmd_ready),
        .out_data(dram_entry)
    );

    assign dram_deselect = !dram_cmd_valid;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_xfer_wrap: assert property (frame_end |=> xfer_q == 4'h0)
        else $error("transfer counter did not wrap after transfer eleven");
    chk_redrive_copy: assert property (##1 sb_lane_out == $past(sb_lane_in))
        else $error("redriven lanes differ from received lanes");
    chk_sync_report: assert property (frame_end && frame_ok && sync_hit
        |=> status_report ##1 !status_report || frame_end && frame_ok && sync_hit)
        else $error("sync frame did not raise a one-cycle status report");
    chk_sync_clears: assert property (status_report |-> !sync_lost)
        else $error("sync lost stays set after a sync frame");
    chk_idle_deselect: assert property (!dram_cmd_valid |-> dram_deselect)
        else $error("deselect not driven while queue empty");
    chk_bad_frame_drop: assert property (frame_end && !frame_ok && pend_v_q == '0
        |=> pend_v_q == '0 && frame_err)
        else $error("frame with bad check bits was acted on");
    chk_foreign_slot: assert property (frame_end && frame_ok && ft.ftype == sbfl_pkg::FT_DATA
        && ft.slot != addr_q && pend_v_q == '0 |=> pend_v_q == '0)
        else $error("data frame for another slot was accepted");
    chk_addr_latch: assert property (smb_addr_valid |=> addr_q == $past(smb_addr))
        else $error("channel address not taken from management port");
    chk_lane_remap: assert property (remap_en && fault_lane == 4'h0
        |-> lanes_l[8:0] == sb_lane_in[9:1])
        else $error("lanes not shifted around the faulty lane");
    chk_push_stall: assert property (push_valid && !push_ready && !frame_end
        |=> pend_v_q == $past(pend_v_q))
        else $error("pending command lost while queue full");
endmodule : sbfl_link

// *** test/sbfl_ctrl_model.sv ***
// Controller-side model that streams back-to-back southbound frames.
module sbfl_ctrl_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic f_valid,
    input wire logic [23:0] f_cmd,
    input wire logic [5:0] f_ft,
    input wire logic [71:0] f_pay,
    input wire logic f_bad,
    output logic load_now,
    output logic sb_frame_mark,
    output logic [9:0] sb_lane_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] x_q;
    logic [119:0] frm_q;
    logic [17:0] pc;

    function automatic logic [17:0] crc18(input logic [71:0] d, input int n);
        logic [17:0] c;
        c = 18'h3FFFF;
        for (int i = 0; i < n; i++) begin
            if (c[17] ^ d[i]) begin
                c = {c[16:0], 1'b0} ^ sbfl_pkg::CRC_POLY;
            end else begin
                c = {c[16:0], 1'b0};
            end
        end
        return c;
    endfunction : crc18

    // A bad frame flips one head CRC bit; the leftover chain still follows the true payload.
    function automatic logic [119:0] build(input logic [23:0] cm, input logic [5:0] ft,
            input logic [71:0] pay, input logic [13:0] left, input logic bad);
        logic [17:0] h;
        logic [17:0] p;
        h = crc18({42'h0, ft, cm}, 30);
        p = crc18(pay, 72);
        return {p[3:0], pay, h[13:0] ^ left ^ {13'h0, bad}, ft, cm};
    endfunction : build

    assign pc = crc18(frm_q[115:44], 72);
    assign load_now = (x_q == sbfl_pkg::LAST_XFER);
    assign sb_frame_mark = (x_q == 4'h0);
    assign sb_lane_in = frm_q[x_q * 10 +: 10];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            x_q <= 4'h0;
            frm_q <= build(24'h0, 6'h0, 72'h0, 14'h0, 1'b0);
        end else if (load_now) begin
            x_q <= 4'h0;
            frm_q <= f_valid ? build(f_cmd, f_ft, f_pay, pc[17:4], f_bad)
                : build(24'h0, 6'h0, 72'h0, pc[17:4], 1'b0);
        end else begin
            x_q <= x_q + 4'h1;
        end
    end
endmodule : sbfl_ctrl_model

// *** test/sbfl_link_tb_top.sv ***
// Self-checking bench for the southbound frame receiver.
module sbfl_link_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic f_valid = 1'b0;
    logic [23:0] f_cmd = 24'h0;
    logic [5:0] f_ft = 6'h0;
    logic [71:0] f_pay = 72'h0;
    logic f_bad = 1'b0;
    logic load_now;
    logic sb_frame_mark;
    logic [9:0] sb_lane_in;
    logic [9:0] sb_lane_out;
    logic [9:0] lane_prev = 10'h0;
    logic smb_addr_valid = 1'b0;
    logic [2:0] smb_addr = 3'h0;
    logic dram_cmd_valid;
    logic dram_cmd_ready = 1'b0;
    sbfl_pkg::sbfl_entry_s dram_entry;
    logic dram_deselect;
    logic status_report;
    logic frame_err;
    logic queue_overrun;
    logic sync_lost;
    logic redrv_on = 1'b0;
    logic remap_en = 1'b0;
    logic [3:0] fault_lane = 4'h0;
    int bad_count = 0;
    int n_checks = 0;
    int err_n = 0;
    int stat_n = 0;
    int ovr_n = 0;

    always #2 ref_clk = ~ref_clk;

    sbfl_ctrl_model i_sbfl_ctrl_model (.ref_clk(ref_clk), .rst_n(rst_n), .f_valid(f_valid),
        .f_cmd(f_cmd), .f_ft(f_ft), .f_pay(f_pay), .f_bad(f_bad), .load_now(load_now),
        .sb_frame_mark(sb_frame_mark), .sb_lane_in(sb_lane_in));

    sbfl_link i_sbfl_link (.ref_clk(ref_clk), .rst_n(rst_n), .sb_lane_in(sb_lane_in),
        .sb_frame_mark(sb_frame_mark), .sb_lane_out(sb_lane_out), .remap_en(remap_en),
        .fault_lane(fault_lane), .smb_addr_valid(smb_addr_valid), .smb_addr(smb_addr),
        .dram_cmd_valid(dram_cmd_valid), .dram_cmd_ready(dram_cmd_ready),
        .dram_entry(dram_entry), .dram_deselect(dram_deselect),
        .status_report(status_report), .frame_err(frame_err),
        .queue_overrun(queue_overrun), .sync_lost(sync_lost));

    always @(posedge ref_clk) begin
        lane_prev <= sb_lane_in;
        if (frame_err === 1'b1) err_n++;
        if (status_report === 1'b1) stat_n++;
        if (queue_overrun === 1'b1) ovr_n++;
    end

    always @(negedge ref_clk) begin
        if (redrv_on) chk_lane(sb_lane_out, lane_prev);
    end

    task automatic test_done();
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    task automatic note(input bit ok, input logic [96:0] got, input logic [96:0] exp);
        n_checks++;
        if (!ok) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : note

    task automatic chk_flag(input logic got, input logic exp);
        note(got === exp, {96'h0, got}, {96'h0, exp});
    endtask : chk_flag

    task automatic chk_lane(input logic [9:0] got, input logic [9:0] exp);
        note(got === exp, {87'h0, got}, {87'h0, exp});
    endtask : chk_lane

    // Write data of a plain command entry carries no meaning, so it is not compared.
    task automatic chk_ent(input sbfl_pkg::sbfl_entry_s got, input sbfl_pkg::sbfl_entry_s exp);
        note(exp.has_data ? got === exp : got[96:72] === exp[96:72], got, exp);
    endtask : chk_ent

    task automatic chk_cnt(input int got, input int exp);
        note(got == exp, 97'(got), 97'(exp));
    endtask : chk_cnt

    function automatic logic [23:0] cm(input logic [2:0] s, input logic [3:0] op,
            input logic [16:0] b);
        return {s, op, b};
    endfunction : cm

    function automatic sbfl_pkg::sbfl_entry_s en(input logic hd, input logic [23:0] c,
            input logic [71:0] w);
        return {hd, c, w};
    endfunction : en

    task automatic send(input logic [23:0] c, input logic [5:0] ft, input logic [71:0] pay,
            input logic bad);
        @(negedge ref_clk);
        f_cmd = c;
        f_ft = ft;
        f_pay = pay;
        f_bad = bad;
        f_valid = 1'b1;
        while (load_now !== 1'b1) @(negedge ref_clk);
        @(negedge ref_clk);
        f_valid = 1'b0;
    endtask : send

    task automatic wait_frames(input int n);
        repeat (n) begin
            @(negedge ref_clk);
            while (load_now !== 1'b1) @(negedge ref_clk);
        end
    endtask : wait_frames

    task automatic pop_chk(input sbfl_pkg::sbfl_entry_s exp);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (dram_cmd_valid !== 1'b1 && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        chk_ent(dram_entry, exp);
        dram_cmd_ready = 1'b1;
        @(negedge ref_clk);
        dram_cmd_ready = 1'b0;
    endtask : pop_chk

    task automatic t_no_addr();
        send(cm(3'h0, 4'h2, 17'h1), 6'h0, 72'h0, 1'b0);
        wait_frames(2);
        chk_flag(dram_cmd_valid, 1'b0);
        chk_flag(dram_deselect, 1'b1);
        @(negedge ref_clk);
        smb_addr = 3'h3;
        smb_addr_valid = 1'b1;
        @(negedge ref_clk);
        smb_addr_valid = 1'b0;
    endtask : t_no_addr

    task automatic t_cmd();
        send(cm(3'h3, 4'h2, 17'h11), 6'h0,
            {24'h0, cm(3'h3, 4'h4, 17'h13), cm(3'h5, 4'h3, 17'h12)}, 1'b0);
        pop_chk(en(1'b0, cm(3'h3, 4'h2, 17'h11), 72'h0));
        pop_chk(en(1'b0, cm(3'h3, 4'h4, 17'h13), 72'h0));
        wait_frames(1);
        chk_flag(dram_cmd_valid, 1'b0);
    endtask : t_cmd

    task automatic t_data();
        send(cm(3'h3, 4'h5, 17'h21), 6'h0D, 72'h12_3456_789A_BCDE_F012, 1'b0);
        send(cm(3'h3, 4'h5, 17'h22), 6'h11, 72'hFF, 1'b0);
        pop_chk(en(1'b1, cm(3'h3, 4'h5, 17'h21), 72'h12_3456_789A_BCDE_F012));
        wait_frames(2);
        chk_flag(dram_cmd_valid, 1'b0);
    endtask : t_data

    task automatic t_part();
        send(cm(3'h3, 4'h6, 17'h31), 6'h0E,
            {24'h0, 24'hABCDEF, cm(3'h3, 4'h7, 17'h32)}, 1'b0);
        pop_chk(en(1'b0, cm(3'h3, 4'h6, 17'h31), 72'h0));
        pop_chk(en(1'b1, cm(3'h3, 4'h7, 17'h32), 72'hABCDEF));
    endtask : t_part

    task automatic t_bad();
        int e0;
        e0 = err_n;
        send(cm(3'h3, 4'h2, 17'h41), 6'h0, 72'h5A_5A5A_5A5A_5A00_0000, 1'b1);
        send(cm(3'h3, 4'h2, 17'h42), 6'h0F, 72'h5A_5A5A_5A5A_5A00_0000, 1'b0);
        send(cm(3'h3, 4'h2, 17'h43), 6'h0, 72'h0, 1'b0);
        pop_chk(en(1'b0, cm(3'h3, 4'h2, 17'h43), 72'h0));
        wait_frames(1);
        chk_cnt(err_n, e0 + 2);
        chk_flag(dram_cmd_valid, 1'b0);
    endtask : t_bad

    task automatic t_sync();
        int s0;
        wait_frames(44);
        chk_flag(sync_lost, 1'b1);
        s0 = stat_n;
        send(cm(3'h0, sbfl_pkg::OP_SYNC, 17'h0), 6'h0, 72'h0, 1'b0);
        wait_frames(2);
        chk_cnt(stat_n, s0 + 1);
        chk_flag(sync_lost, 1'b0);
        chk_flag(dram_cmd_valid, 1'b0);
        wait_frames(38);
        chk_flag(sync_lost, 1'b0);
        wait_frames(4);
        chk_flag(sync_lost, 1'b1);
    endtask : t_sync

    // Four frames of three commands overfill the 8-entry queue; the stuck one is overwritten.
    task automatic t_full();
        int o0;
        o0 = ovr_n;
        for (int k = 0; k < 4; k++) begin
            send(cm(3'h3, 4'h2, 17'(80 + 3 * k)), 6'h0, {24'h0,
                cm(3'h3, 4'h4, 17'(82 + 3 * k)), cm(3'h3, 4'h3, 17'(81 + 3 * k))}, 1'b0);
        end
        wait_frames(2);
        chk_cnt(ovr_n, o0 + 1);
        chk_flag(dram_deselect, 1'b0);
        for (int k = 0; k < 4; k++) begin
            for (int j = 0; j < 3; j++) begin
                if (!(k == 2 && j == 2)) begin
                    pop_chk(en(1'b0, cm(3'h3, 4'(2 + j), 17'(80 + 3 * k + j)), 72'h0));
                end
            end
        end
        wait_frames(1);
        chk_flag(dram_cmd_valid, 1'b0);
    endtask : t_full

    // Remapping acts on the receive side only; the redrive keeps forwarding raw lanes.
    task automatic t_remap();
        @(negedge ref_clk);
        fault_lane = 4'h0;
        remap_en = 1'b1;
        wait_frames(2);
        chk_flag(dram_deselect, !dram_cmd_valid);
    endtask : t_remap

    initial begin
        repeat (5) @(posedge ref_clk);
        chk_flag(dram_deselect, 1'b1);
        chk_flag(dram_cmd_valid, 1'b0);
        @(negedge ref_clk);
        rst_n = 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        redrv_on = 1'b1;
        t_no_addr();
        t_cmd();
        t_data();
        t_part();
        t_bad();
        t_sync();
        t_full();
        t_remap();
        test_done();
    end

    // The tests take about 120 frames of 12 cycles; the limit leaves ample margin.
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        test_done();
    end
endmodule : sbfl_link_tb_top
